// *** verilog/dsc_map.svh ***
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// opcode field position in every fetched word
`define DSC_OPC_MSB 23
`define DSC_OPC_LSB 16
// opcode values per class (values chosen for this core)
`define DSC_OP_NOP 8'h00
`define DSC_OP_TWO_A 8'h02
`define DSC_OP_TWO_B 8'h04
`define DSC_OP_TWO_C 8'h08
`define DSC_RELATIVE_JUMP_OP 8'h37
`define DSC_OP_IND_JUMP 8'h01
`define DSC_OP_TBL_RD 8'hBA
`define DSC_OP_TBL_WR 8'hBB
`define DSC_OP_SUB_EXIT 8'h06
`define DSC_INTERRUPT_EXIT_OP 8'h07
`define DSC_OP_SKIP_A 8'hA6
`define DSC_OP_SKIP_B 8'hA7
`define DSC_OP_MOVE_DBL 8'hBE
`define DSC_OP_MULT_ACC 8'hC0
`define DSC_OP_SQUARE 8'hC1
`define DSC_OP_DSP_ADD 8'hCB
`define DSC_OP_FILE 8'hB4
`define DSC_OP_BITOP 8'hA0
`define DSC_OP_ULIT 8'hB0
`define DSC_OP_SLIT 8'hB2
// operand field positions
`define DSC_F_MSB 12
`define DSC_DEST_SEL 13
`define DSC_BYTE_SEL 14
`define DSC_LIT_MSB 13
`define DSC_LIT_LSB 4
`define DSC_BIT_MSB 15
`define DSC_BIT_LSB 12
`define DSC_BASE_MSB 18
`define DSC_BASE_LSB 15
`define DSC_DST_MSB 10
`define DSC_DST_LSB 7
`define DSC_ACC_SEL 15
`define DSC_AWB_SEL 14
// pair code sits below the accumulator and write-back selects, clear of the opcode
`define DSC_PAIR_MSB 13
`define DSC_PAIR_LSB 11
`define DSC_FILE_OP_DEFAULT_REGISTER 4'h0
`define DSC_ACC_WRITEBACK_REG 4'hD
`define DSC_BYTE_LIT_MAX 10'h0FF
// register offsets and reset values
`define DSC_REG_CTRL 2'h0
`define DSC_REG_FLAGS 2'h1
`define DSC_REG_ERR 2'h2
`define DSC_REG_LAST 2'h3
`define DSC_CTRL_RST 1'b1
`endif

// *** verilog/dsc_pkg.sv ***
`default_nettype none
package dsc_pkg;
   typedef enum logic [3:0] {
      CLS_NOP, CLS_PLAIN, CLS_TWO, CLS_LONG, CLS_SKIP, CLS_MOVD,
      CLS_MULT, CLS_SQR, CLS_DSP, CLS_FILE, CLS_BIT, CLS_ULIT, CLS_SLIT
   } dsc_cls_e;
   typedef enum logic [2:0] {
      ST_RUN, ST_SECOND, ST_STALL, ST_SKIP1, ST_SKIP2
   } dsc_st_e;
   typedef struct packed {
      dsc_st_e     st;
      logic [1:0]  cnt;
      logic        ready;
      logic        issue;
      logic        nop;
      logic        second;
      logic [7:0]  opcode;
      dsc_cls_e    cls;
      logic [12:0] faddr;
      logic        to_file_op_default_register;
      logic        byte_sel;
      logic        dword;
      logic [9:0]  ulit;
      logic [15:0] slit;
      logic [22:0] pal;
      logic [3:0]  bitpos;
      logic [3:0]  base;
      logic [3:0]  src2;
      logic [3:0]  dest;
      logic        acc_b;
      logic [3:0]  mul_a;
      logic [3:0]  mul_b;
      logic        awb_inc;
      logic [4:0]  upd_mcu;
      logic [3:0]  upd_dsp;
      logic [1:0]  cycles;
      logic        en;
      logic [4:0]  mcu;
      logic [3:0]  dsp;
      logic [3:0]  err;
      logic        ack;
      logic [31:0] rdat;
   } dsc_state_s;
endpackage
`default_nettype wire

// *** verilog/dsc_idec.sv ***
// Contract
// - single word is 24 bits: 8-bit opcode then operand fields
// - only three opcodes take two words; all others take one
// - two-word form holds 48 bits; second word top byte is zero
// - a stray second word executes as no operation
// - two-word instructions take two instruction cycles
// - one cycle, two when condition true or program counter changes
// - jumps, calls, table access and returns take two or three cycles
// - taken skip costs two cycles, three over a two-word instruction
// - double-word moves take two cycles
// - file operand address spans 0 to 0x1FFF
// - file result goes to the file register or working register zero
// - 23-bit program address literal always has bit zero clear
// - unsigned 10-bit literal is 0..255 for bytes, 0..1023 for words
// - word size by default; suffix picks byte or double word
// - multiply class selects accumulator A or B plus operand fields
// - accumulator write-back goes to W13 or [W13] post-increment by 2
// - alu updates carry, digit carry, negative, excess; zero is sticky
// - dsp updates excess and clamp flags per accumulator
// - bit position field is 4 bits, positions 0 to 15
// - signed 10-bit literal is two's complement, -512 to 511
// - base source register is any of W0..W15, no modifier
// - square uses one register W4..W7; others a distinct pair there
`timescale 1ns/1ps
`default_nettype none
`include "dsc_map.svh"
module dsc_idec
   import dsc_pkg::*;
#(
   parameter int ADR_W = 8
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // classic wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // fetch side
   input  wire logic        instr_valid_i,
   input  wire logic [23:0] instr_word_i,
   input  wire logic        cond_true_i,
   input  wire logic        pc_change_i,
   input  wire logic        third_cycle_i,
   output logic             ready_o,
   // datapath results
   input  wire logic        alu_done_i,
   input  wire logic [4:0]  alu_flags_i,
   input  wire logic        dsp_done_i,
   input  wire logic [1:0]  dsp_flags_i,
   // decoded instruction
   output logic             issue_o,
   output logic             nop_o,
   output logic             second_o,
   output logic [1:0]       exec_cycles_o,
   output logic [7:0]       opcode_o,
   output logic [12:0]      file_addr_o,
   output logic             to_default_reg_o,
   output logic             byte_op_o,
   output logic             dword_op_o,
   output logic [9:0]       ten_bit_unsigned_literal_o,
   output logic [15:0]      ten_bit_signed_literal_o,
   output logic [22:0]      program_address_literal_o,
   output logic [3:0]       bit_position_field_o,
   output logic [3:0]       base_source_reg_o,
   output logic [3:0]       second_source_operand_o,
   output logic [3:0]       result_destination_operand_o,
   output logic             acc_b_sel_o,
   output logic [3:0]       mul_reg_a_o,
   output logic [3:0]       mul_reg_b_o,
   output logic [3:0]       acc_writeback_target_o,
   output logic             acc_writeback_postinc_o,
   output logic [4:0]       upd_mcu_flags_o,
   output logic [3:0]       upd_dsp_flags_o
);
   // the unmapped-address test needs at least one bit above the word index
   if (ADR_W < 5) begin : g_chk
      $error("ADR_W must be at least 5");
   end

   dsc_state_s s, n;

   function automatic dsc_cls_e dsc_class(input logic [7:0] op);
      case (op)
         `DSC_OP_NOP:            return CLS_NOP;
         `DSC_OP_TWO_A,
         `DSC_OP_TWO_B,
         `DSC_OP_TWO_C:          return CLS_TWO;
         `DSC_RELATIVE_JUMP_OP,
         `DSC_OP_IND_JUMP,
         `DSC_OP_TBL_RD,
         `DSC_OP_TBL_WR,
         `DSC_OP_SUB_EXIT,
         `DSC_INTERRUPT_EXIT_OP: return CLS_LONG;
         `DSC_OP_SKIP_A,
         `DSC_OP_SKIP_B:         return CLS_SKIP;
         `DSC_OP_MOVE_DBL:       return CLS_MOVD;
         `DSC_OP_MULT_ACC:       return CLS_MULT;
         `DSC_OP_SQUARE:         return CLS_SQR;
         `DSC_OP_DSP_ADD:        return CLS_DSP;
         `DSC_OP_FILE:           return CLS_FILE;
         `DSC_OP_BITOP:          return CLS_BIT;
         `DSC_OP_ULIT:           return CLS_ULIT;
         `DSC_OP_SLIT:           return CLS_SLIT;
         default:                return CLS_PLAIN;
      endcase
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   logic        acc;
   logic [23:0] w;
   dsc_cls_e    c;
   logic        hit;
   logic        mapped;
   logic [31:0] m;
   logic [31:0] nv;

   always_comb begin
      n = s;
      n.issue = 1'b0;
      n.nop = 1'b0;
      n.second = 1'b0;
      acc = instr_valid_i & s.ready;
      w = instr_word_i;
      c = dsc_class(w[`DSC_OPC_MSB:`DSC_OPC_LSB]);
      hit = cyc_i & stb_i & ~s.ack;
      mapped = (adr_i[ADR_W-1:4] == '0);
      m = lane_mask(sel_i);
      nv = 32'h0000_0000;

      // register bus: ack one cycle after the strobe, dropped next
      n.ack = hit;
      if (hit & ~we_i) begin
         n.rdat = 32'h0000_0000;
         if (mapped) begin
            case (adr_i[3:2])
               `DSC_REG_CTRL:  n.rdat = {31'h0, s.en};
               `DSC_REG_FLAGS: n.rdat = {20'h0, s.dsp, 3'h0, s.mcu};
               `DSC_REG_ERR:   n.rdat = {28'h0, s.err};
               `DSC_REG_LAST:  n.rdat = {22'h0, s.cycles, s.opcode};
               default:        n.rdat = 32'h0000_0000;
            endcase
         end
      end
      if (hit & we_i & mapped) begin
         case (adr_i[3:2])
            `DSC_REG_CTRL: begin
               nv = ({31'h0, s.en} & ~m) | (dat_i & m);
               n.en = nv[0];
            end
            `DSC_REG_FLAGS: begin
               nv = ({20'h0, s.dsp, 3'h0, s.mcu} & ~m) | (dat_i & m);
               n.mcu = nv[4:0];
               n.dsp = nv[11:8];
            end
            // write one to clear; a hardware set below still wins
            `DSC_REG_ERR: n.err = s.err & ~(dat_i[3:0] & m[3:0]);
            default: ;
         endcase
      end

      // status flags; alu results only ever clear zero, so a multi-word chain keeps it
      if (alu_done_i) begin
         for (int i = 1; i < 5; i++) begin
            if (s.upd_mcu[i]) n.mcu[i] = alu_flags_i[i];
         end
         if (s.upd_mcu[0]) n.mcu[0] = n.mcu[0] & alu_flags_i[0];
      end
      if (dsp_done_i) begin
         n.dsp = (n.dsp & ~s.upd_dsp) |
                 ({{2{dsp_flags_i[1]}}, {2{dsp_flags_i[0]}}} & s.upd_dsp);
      end

      case (s.st)
         ST_RUN: begin
            if (acc) begin
               n.opcode = w[`DSC_OPC_MSB:`DSC_OPC_LSB];
               n.cls = c;
               n.faddr = w[`DSC_F_MSB:0];
               n.to_file_op_default_register = (c == CLS_FILE) & w[`DSC_DEST_SEL];
               n.dword = (c == CLS_MOVD);
               n.byte_sel = ~n.dword & w[`DSC_BYTE_SEL];
               n.ulit = w[`DSC_LIT_MSB:`DSC_LIT_LSB];
               n.slit = {{6{w[`DSC_LIT_MSB]}}, w[`DSC_LIT_MSB:`DSC_LIT_LSB]};
               n.bitpos = w[`DSC_BIT_MSB:`DSC_BIT_LSB];
               n.base = w[`DSC_BASE_MSB:`DSC_BASE_LSB];
               n.src2 = w[3:0];
               n.dest = n.to_file_op_default_register ? `DSC_FILE_OP_DEFAULT_REGISTER
                                  : w[`DSC_DST_MSB:`DSC_DST_LSB];
               n.acc_b = w[`DSC_ACC_SEL];
               n.awb_inc = w[`DSC_AWB_SEL];
               n.pal = {7'h00, w[15:1], 1'b0};
               if (c == CLS_TWO && w[0]) n.err[3] = 1'b1;
               if (c == CLS_ULIT && n.byte_sel && n.ulit > `DSC_BYTE_LIT_MAX) begin
                  n.err[1] = 1'b1;
               end
               // operand pair: square repeats one register, others distinct
               n.mul_a = 4'h4;
               n.mul_b = 4'h5;
               if (c == CLS_SQR) begin
                  n.mul_a = {2'b01, w[`DSC_PAIR_LSB+1:`DSC_PAIR_LSB]};
                  n.mul_b = n.mul_a;
               end else if (c == CLS_MULT) begin
                  case (w[`DSC_PAIR_MSB:`DSC_PAIR_LSB])
                     3'h0: begin n.mul_a = 4'h4; n.mul_b = 4'h5; end
                     3'h1: begin n.mul_a = 4'h4; n.mul_b = 4'h6; end
                     3'h2: begin n.mul_a = 4'h4; n.mul_b = 4'h7; end
                     3'h3: begin n.mul_a = 4'h5; n.mul_b = 4'h6; end
                     3'h4: begin n.mul_a = 4'h5; n.mul_b = 4'h7; end
                     3'h5: begin n.mul_a = 4'h6; n.mul_b = 4'h7; end
                     default: n.err[2] = 1'b1;
                  endcase
               end
               n.upd_mcu = (c == CLS_FILE || c == CLS_ULIT ||
                            c == CLS_SLIT || c == CLS_PLAIN) ? 5'h1F : 5'h00;
               n.upd_dsp = (c == CLS_MULT || c == CLS_SQR || c == CLS_DSP)
                           ? (n.acc_b ? 4'hA : 4'h5) : 4'h0;
               n.issue = (c != CLS_NOP);
               n.nop = (c == CLS_NOP);
               n.cycles = 2'd1;
               case (c)
                  CLS_TWO: begin
                     n.st = ST_SECOND;
                     n.cycles = 2'd2;
                  end
                  CLS_LONG: begin
                     n.st = ST_STALL;
                     n.cnt = third_cycle_i ? 2'd2 : 2'd1;
                     n.cycles = third_cycle_i ? 2'd3 : 2'd2;
                  end
                  CLS_MOVD: begin
                     n.st = ST_STALL;
                     n.cnt = 2'd1;
                     n.cycles = 2'd2;
                  end
                  CLS_SKIP: begin
                     if (cond_true_i) n.st = ST_SKIP1;
                  end
                  CLS_NOP: ;
                  default: begin
                     if (cond_true_i | pc_change_i) begin
                        n.st = ST_STALL;
                        n.cnt = 2'd1;
                        n.cycles = 2'd2;
                     end
                  end
               endcase
            end
         end
         ST_SECOND: begin
            if (acc) begin
               n.second = 1'b1;
               n.pal[22:16] = w[6:0];
               if (w[`DSC_OPC_MSB:`DSC_OPC_LSB] != `DSC_OP_NOP) n.err[0] = 1'b1;
               n.st = ST_RUN;
            end
         end
         ST_STALL: begin
            n.nop = 1'b1;
            n.cnt = s.cnt - 2'd1;
            if (s.cnt == 2'd1) n.st = ST_RUN;
         end
         ST_SKIP1: begin
            if (acc) begin
               n.nop = 1'b1;
               n.st = (c == CLS_TWO) ? ST_SKIP2 : ST_RUN;
            end
         end
         ST_SKIP2: begin
            if (acc) begin
               n.nop = 1'b1;
               n.st = ST_RUN;
            end
         end
         default: n.st = ST_RUN;
      endcase
      // fetch is held off only while stall bubbles run or software disables
      n.ready = n.en & (n.st != ST_STALL);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.en <= `DSC_CTRL_RST;
         s.ready <= `DSC_CTRL_RST;
      end else begin
         s <= n;
      end
   end

   assign dat_o = s.rdat;
   assign ack_o = s.ack;
   assign ready_o = s.ready;
   assign issue_o = s.issue;
   assign nop_o = s.nop;
   assign second_o = s.second;
   assign exec_cycles_o = s.cycles;
   assign opcode_o = s.opcode;
   assign file_addr_o = s.faddr;
   assign to_default_reg_o = s.to_file_op_default_register;
   assign byte_op_o = s.byte_sel;
   assign dword_op_o = s.dword;
   assign ten_bit_unsigned_literal_o = s.ulit;
   assign ten_bit_signed_literal_o = s.slit;
   assign program_address_literal_o = s.pal;
   assign bit_position_field_o = s.bitpos;
   assign base_source_reg_o = s.base;
   assign second_source_operand_o = s.src2;
   assign result_destination_operand_o = s.dest;
   assign acc_b_sel_o = s.acc_b;
   assign mul_reg_a_o = s.mul_a;
   assign mul_reg_b_o = s.mul_b;
   assign acc_writeback_target_o = `DSC_ACC_WRITEBACK_REG;
   assign acc_writeback_postinc_o = s.awb_inc;
   assign upd_mcu_flags_o = s.upd_mcu;
   assign upd_dsp_flags_o = s.upd_dsp;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_take_zero;
      acc && s.st == ST_RUN && c == CLS_NOP;
   endsequence
   sequence seq_take_second;
      acc && s.st == ST_SECOND;
   endsequence
   sequence seq_long3;
      issue_o && exec_cycles_o == 2'd3;
   endsequence
   sequence seq_skip_taken;
      acc && s.st == ST_RUN && c == CLS_SKIP && cond_true_i;
   endsequence
   sequence seq_skip_drop;
      acc && (s.st == ST_SKIP1 || s.st == ST_SKIP2);
   endsequence

   AST_ZERO_NOP: assert property (seq_take_zero |=> nop_o && !issue_o)
      else $error("zero opcode word was not a nop");
   AST_SECOND_WORD: assert property (seq_take_second |=> second_o && exec_cycles_o == 2'd2)
      else $error("second word not closed in two cycles");
   AST_LONG_STALL: assert property (seq_long3 |-> !ready_o ##1 (!ready_o && nop_o) ##1 (ready_o || !s.en))
      else $error("three-cycle instruction stall wrong");
   AST_SKIP_ARM: assert property (seq_skip_taken |=> issue_o && s.st == ST_SKIP1)
      else $error("taken skip did not arm the bubble");
   AST_SKIP_BUBBLE: assert property (seq_skip_drop |=> nop_o && !issue_o)
      else $error("skipped word was issued");
   AST_ADDR_EVEN: assert property (second_o |-> program_address_literal_o[0] == 1'b0)
      else $error("program address literal odd");
   AST_BYTE_LIT: assert property (acc && s.st == ST_RUN && c == CLS_ULIT && w[`DSC_BYTE_SEL]
                                  && w[`DSC_LIT_MSB:`DSC_LIT_LSB] > `DSC_BYTE_LIT_MAX |=> s.err[1])
      else $error("byte literal overrange not flagged");
   AST_SIGNED_LIT: assert property (issue_o |-> $signed(ten_bit_signed_literal_o) >= -16'sd512
                                    && $signed(ten_bit_signed_literal_o) <= 16'sd511)
      else $error("signed literal out of range");
   AST_PAIR: assert property (issue_o && s.cls == CLS_MULT |-> mul_reg_a_o != mul_reg_b_o
                              && mul_reg_a_o[3:2] == 2'b01 && mul_reg_b_o[3:2] == 2'b01)
      else $error("multiply register pair invalid");
   AST_Z_STICKY: assert property (alu_done_i && s.upd_mcu[0] && !alu_flags_i[0] |=> !s.mcu[0])
      else $error("zero flag not cleared");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// *** tb/dsc_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsc_fetch_model (
   // clock and handshake
   input  wire logic   clk_i,
   input  wire logic   ready_i,
   // fetched word
   output logic        valid_o,
   output logic [23:0] word_o,
   output logic        cond_o,
   output logic        pc_o,
   output logic        third_o,
   // datapath completion
   output logic        alu_done_o,
   output logic [4:0]  alu_flags_o,
   output logic        dsp_done_o,
   output logic [1:0]  dsp_flags_o
);
   int stuck;
   initial begin
      stuck = 0;
      valid_o = 1'h0;
      word_o = 24'h0;
      cond_o = 1'h0;
      pc_o = 1'h0;
      third_o = 1'h0;
      alu_done_o = 1'h0;
      alu_flags_o = 5'h0;
      dsp_done_o = 1'h0;
      dsp_flags_o = 2'h0;
   end
   // word held until an edge that sees ready high
   task automatic put(input logic [23:0] w, input logic c, input logic p, input logic t);
      int n;
      n = 0;
      valid_o <= 1'h1;
      word_o <= w;
      cond_o <= c;
      pc_o <= p;
      third_o <= t;
      @(posedge clk_i);
      while (ready_i !== 1'h1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 20) stuck++;
   endtask
   // released word shows its inverse and valid, cond, pc, third drop low, so stale data never looks valid
   task automatic idle();
      valid_o <= 1'h0;
      word_o <= ~word_o;
      cond_o <= 1'h0;
      pc_o <= 1'h0;
      third_o <= 1'h0;
   endtask
   task automatic finish(input logic a, input logic [4:0] af, input logic d, input logic [1:0] df);
      alu_done_o <= a;
      alu_flags_o <= af;
      dsp_done_o <= d;
      dsp_flags_o <= df;
      @(posedge clk_i);
      alu_done_o <= 1'h0;
      alu_flags_o <= ~af;
      dsp_done_o <= 1'h0;
      dsp_flags_o <= ~df;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   logic        clk, rst, cyc, stb, we, ack, valid, cond, pc, third, ready, adone, ddone;
   logic [7:0]  adr, opc;
   logic [3:0]  sel, bitpos, mula, mulb, acc_writeback_target, dest;
   logic [31:0] wdat, rdat;
   logic [23:0] word;
   logic [4:0]  aflags, umcu;
   logic [3:0]  base, src2, udsp;
   logic [1:0]  dflags, exec;
   logic        issue, nop, second, to_def, byte_op, dword, acc_b, postinc;
   logic [12:0] faddr;
   logic [9:0]  ulit;
   logic [15:0] slit;
   logic [22:0] pal;
   int          errors, checks, n_issue, n_nop, n_sec, n_stall;

   dsc_idec dsc_idec_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .instr_valid_i(valid), .instr_word_i(word),
      .cond_true_i(cond), .pc_change_i(pc), .third_cycle_i(third), .ready_o(ready), .alu_done_i(adone),
      .alu_flags_i(aflags), .dsp_done_i(ddone), .dsp_flags_i(dflags), .issue_o(issue), .nop_o(nop),
      .second_o(second), .exec_cycles_o(exec), .opcode_o(opc), .file_addr_o(faddr), .to_default_reg_o(to_def),
      .byte_op_o(byte_op), .dword_op_o(dword), .ten_bit_unsigned_literal_o(ulit),
      .ten_bit_signed_literal_o(slit), .program_address_literal_o(pal), .bit_position_field_o(bitpos),
      .base_source_reg_o(base), .second_source_operand_o(src2), .result_destination_operand_o(dest),
      .acc_b_sel_o(acc_b), .mul_reg_a_o(mula), .mul_reg_b_o(mulb), .acc_writeback_target_o(acc_writeback_target),
      .acc_writeback_postinc_o(postinc), .upd_mcu_flags_o(umcu), .upd_dsp_flags_o(udsp));
   dsc_fetch_model dsc_fetch_model_i (.clk_i(clk), .ready_i(ready), .valid_o(valid), .word_o(word),
      .cond_o(cond), .pc_o(pc), .third_o(third), .alu_done_o(adone), .alu_flags_o(aflags),
      .dsp_done_o(ddone), .dsp_flags_o(dflags));

   initial clk = 1'h0;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (issue === 1'h1) n_issue++;
      if (nop === 1'h1) n_nop++;
      if (second === 1'h1) n_sec++;
      if (ready === 1'h0 && rst === 1'h0) n_stall++;
   end

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      // only the watchdog ends a wait for ack
      while (ack !== 1'h1) @(posedge clk);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'h1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      wb(1'h0, a, 32'h0, q);
      `CHK(nm, e, q)
   endtask
   task automatic p(input logic [23:0] w, input logic c = 1'h0, input logic q = 1'h0, input logic t = 1'h0);
      dsc_fetch_model_i.put(w, c, q, t);
   endtask
   // longest stall is two bubbles, four edges let every field land
   task automatic s();
      dsc_fetch_model_i.idle();
      repeat (4) @(posedge clk);
   endtask

   task automatic t_reset();
      `CHK("ready", 1'h1, ready)
      rd(8'h00, 32'h1, "ctrl");
      rd(8'h04, 32'h0, "flags");
      rd(8'h08, 32'h0, "err");
      rd(8'h0C, 32'h0, "last");
      wr(8'h10, 32'h0);
      rd(8'h10, 32'h0, "unmapped");
      rd(8'h00, 32'h1, "ctrl kept");
      wr(8'h00, 32'h0);
      @(posedge clk);
      `CHK("ready off", 1'h0, ready)
      wr(8'h00, 32'h1);
   endtask
   task automatic t_two();
      logic [7:0] ops [3] = '{8'h02, 8'h04, 8'h08};
      int a, b;
      foreach (ops[i]) begin
         a = n_issue;
         b = n_sec;
         p({ops[i], 16'h1234});
         p(24'h000055);
         s();
         `CHK("two exec", 2'h2, exec)
         `CHK("two issue", 1, n_issue - a)
         `CHK("two second", 1, n_sec - b)
         `CHK("addr lit", {7'h55, 15'h091A, 1'h0}, pal)
      end
      a = n_nop;
      b = n_issue;
      p(24'h000055);
      s();
      `CHK("stray nop", 1, n_nop - a)
      `CHK("stray issue", 0, n_issue - b)
      p(24'h020001);
      p(24'h010000);
      s();
      rd(8'h08, 32'h9, "err two");
      wr(8'h08, 32'hF);
      rd(8'h08, 32'h0, "err clr");
   endtask
   task automatic t_long();
      logic [7:0] ops [6] = '{8'h37, 8'h01, 8'hBA, 8'hBB, 8'h06, 8'h07};
      int a, b;
      for (int t = 0; t < 2; t++) begin
         foreach (ops[i]) begin
            a = n_nop;
            b = n_stall;
            p({ops[i], 16'h0}, 1'h0, 1'h0, t[0]);
            s();
            `CHK("long exec", 2'(2 + t), exec)
            `CHK("long nop", 1 + t, n_nop - a)
            `CHK("long stall", 1 + t, n_stall - b)
         end
      end
      rd(8'h0C, 32'h307, "last");
   endtask
   task automatic t_single();
      int a, b;
      a = n_issue;
      b = n_stall;
      p(24'h100000);
      p(24'h104000);
      s();
      `CHK("plain issue", 2, n_issue - a)
      `CHK("plain exec", 2'h1, exec)
      `CHK("plain stall", 0, n_stall - b)
      `CHK("byte op", 1'h1, byte_op)
      p(24'h100000, 1'h1);
      s();
      `CHK("cond exec", 2'h2, exec)
      p(24'h100000, 1'h0, 1'h1);
      s();
      `CHK("pc exec", 2'h2, exec)
      p(24'hBE4000);
      s();
      `CHK("dmove exec", 2'h2, exec)
      `CHK("dmove size", 2'h2, {dword, byte_op})
   endtask
   task automatic t_skip();
      int a, b;
      a = n_issue;
      b = n_nop;
      p(24'hA60000, 1'h1);
      p(24'h100000);
      s();
      `CHK("skip one", 2'h1, 2'(n_nop - b))
      `CHK("skip issue", 1, n_issue - a)
      b = n_nop;
      p(24'hA70000, 1'h1);
      p(24'h020000);
      p(24'h000010);
      s();
      `CHK("skip two", 2, n_nop - b)
      a = n_issue;
      p(24'hA60000);
      p(24'h100000);
      s();
      `CHK("no skip", 2, n_issue - a)
   endtask
   task automatic t_fields();
      p(24'hB43FFF);
      s();
      `CHK("file addr", 13'h1FFF, faddr)
      `CHK("to w0", 5'h10, {to_def, dest})
      `CHK("base src", 8'h8F, {base, src2})
      `CHK("upd mcu", 5'h1F, umcu)
      p(24'hB40780);
      s();
      `CHK("to file", 5'h0F, {to_def, dest})
      `CHK("opcode", 8'hB4, opc)
      p(24'hB03FF0);
      s();
      `CHK("word lit", 10'h3FF, ulit)
      p(24'hB05000);
      s();
      rd(8'h08, 32'h2, "byte lit");
      wr(8'h08, 32'hF);
      p(24'hB22000);
      s();
      `CHK("slit min", 16'hFE00, slit)
      p(24'hB21FF0);
      s();
      `CHK("slit max", 16'h01FF, slit)
      p(24'hA0F000);
      s();
      `CHK("bit pos", 4'hF, bitpos)
      p(24'hC0C000);
      s();
      `CHK("acc b", 1'h1, acc_b)
      `CHK("pair", 8'h45, {mula, mulb})
      `CHK("awb", 5'h1D, {postinc, acc_writeback_target})
      `CHK("upd dsp", 4'hA, udsp)
      p(24'hC10800);
      s();
      `CHK("square", 8'h55, {mula, mulb})
      p(24'hC02800);
      s();
      `CHK("pair 5", 8'h67, {mula, mulb})
      p(24'hC03000);
      s();
      rd(8'h08, 32'h4, "pair code");
      wr(8'h08, 32'hF);
   endtask
   task automatic t_flags();
      wr(8'h04, 32'h1F);
      p(24'hB40000);
      s();
      dsc_fetch_model_i.finish(1'h1, 5'h16, 1'h0, 2'h0);
      rd(8'h04, 32'h16, "alu flags");
      p(24'hB40000);
      s();
      dsc_fetch_model_i.finish(1'h1, 5'h09, 1'h0, 2'h0);
      rd(8'h04, 32'h08, "sticky z");
      p(24'hCB8000);
      s();
      dsc_fetch_model_i.finish(1'h0, 5'h0, 1'h1, 2'h3);
      rd(8'h04, 32'hA08, "dsp flags");
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end
   initial begin
      rst = 1'h1;
      cyc = 1'h0;
      stb = 1'h0;
      we = 1'h0;
      adr = 8'h0;
      sel = 4'hF;
      wdat = 32'h0;
      {errors, checks, n_issue, n_nop, n_sec, n_stall} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_two();
      t_long();
      t_single();
      t_skip();
      t_fields();
      t_flags();
      `CHK("fetch stuck", 0, dsc_fetch_model_i.stuck)
      give_verdict();
   end
endmodule
`default_nettype wire
